/* File: common/aws_pkg.sv */
package aws_pkg;

    // Register offsets (host register space)
    localparam logic [7:0] ADDR_INACT_DUR   = 8'h29;
    localparam logic [7:0] ADDR_SYS_CTRL1   = 8'h2A;
    localparam logic [7:0] ADDR_SYS_CTRL2   = 8'h2B;
    localparam logic [7:0] ADDR_WAKE_SRC    = 8'h2C;
    localparam logic [7:0] ADDR_INT_EN      = 8'h2D;
    localparam logic [7:0] ADDR_SYS_STATUS  = 8'h0B;

    // Reset values
    localparam logic [7:0] RST_INACT_DUR    = 8'h00;
    localparam logic [7:0] RST_SYS_CTRL1    = 8'h00;
    localparam logic [7:0] RST_SYS_CTRL2    = 8'h00;
    localparam logic [7:0] RST_WAKE_SRC     = 8'h00;
    localparam logic [7:0] RST_INT_EN       = 8'h00;

    // Field positions
    localparam int SLEEP_RATE_LSB  = 6;     // System control one [7:6]
    localparam int ACT_RATE_LSB    = 3;     // System control one [5:3]
    localparam int ACTIVE_BIT      = 0;     // System control one [0]
    localparam int AUTO_SLEEP_BIT  = 2;     // System control two [2]
    localparam int FIFO_GATE_BIT   = 7;     // Wake source control [7]
    localparam int WAKE_TRANS_BIT  = 6;
    localparam int WAKE_ORIENT_BIT = 5;
    localparam int WAKE_TAP_BIT    = 4;
    localparam int WAKE_FFMT_BIT   = 3;
    localparam int IEN_SLEEP_BIT   = 7;     // Interrupt enable [7]
    localparam int IEN_TRANS_BIT   = 5;
    localparam int IEN_ORIENT_BIT  = 4;
    localparam int IEN_TAP_BIT     = 3;
    localparam int IEN_FFMT_BIT    = 2;

    // Time bases
    localparam int CLK_PERIOD_NS   = 8;
    localparam int STEP_SHORT_MS   = 320;
    localparam int STEP_LONG_MS    = 640;
    localparam int TICK_US         = 10;    // Base tick from divider
    localparam int TICK_CYC        = (TICK_US * 1000) / CLK_PERIOD_NS;
    localparam int STEP_SHORT_TICK = (STEP_SHORT_MS * 1000) / TICK_US;
    localparam int STEP_LONG_TICK  = (STEP_LONG_MS * 1000) / TICK_US;

    // Sample rate codes (same encoding as active data rate)
    typedef enum logic [2:0] {
        RATE_800  = 3'b000,
        RATE_400  = 3'b001,
        RATE_200  = 3'b010,
        RATE_100  = 3'b011,
        RATE_50   = 3'b100,
        RATE_12P5 = 3'b101,
        RATE_6P25 = 3'b110,
        RATE_1P56 = 3'b111
    } aws_rate_t;

    // Power state
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_WAKE    = 2'b01,
        ST_SLEEP   = 2'b10
    } aws_state_t;

    // Detection events, one-cycle pulses
    typedef struct packed {
        logic transient_event;
        logic orientation_event;
        logic tap_event;
        logic freefall_motion_event;
        logic fifo_gate_event;
        logic sample_ready_event;
    } aws_events_t;

    // Host register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aws_reg_req_t;

endpackage : aws_pkg

/* File: hdl/aws_step_timer.sv */
// Base tick divider and inactivity step counter
module aws_step_timer #(
    parameter int TICK_CYCLES = aws_pkg::TICK_CYC,        // Clocks per tick
    parameter int SHORT_TICKS = aws_pkg::STEP_SHORT_TICK, // Ticks per step
    parameter int LONG_TICKS  = aws_pkg::STEP_LONG_TICK   // At 1.56 Hz
) (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic sys_rst_in,
    // Control
    input  wire logic restart_in,
    input  wire logic long_step_in,
    // Output
    output logic      step_out
);
    import aws_pkg::*;

    logic [15:0] div_q;       // Clock to base tick
    logic [15:0] div_d;
    logic [15:0] tick_q;      // Base ticks within a step
    logic [15:0] tick_d;
    logic        step_q;
    logic        step_d;
    logic        tick_en;
    logic [15:0] step_len;

    // Next values of divider and step counter
    always_comb begin
        tick_en  = (div_q == 16'(TICK_CYCLES - 1));
        step_len = long_step_in ? 16'(LONG_TICKS)
                                : 16'(SHORT_TICKS);
        div_d    = tick_en ? 16'h0000 : div_q + 16'h0001;
        tick_d   = tick_q;
        step_d   = 1'b0;
        if (restart_in) begin
            // Restart both so a full step follows
            div_d  = 16'h0000;
            tick_d = 16'h0000;
        end else if (tick_en) begin
            if (tick_q == step_len - 16'h0001) begin
                tick_d = 16'h0000;
                step_d = 1'b1;
            end else begin
                tick_d = tick_q + 16'h0001;
            end
        end
    end

    // Registers
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            div_q  <= 16'h0000;
            tick_q <= 16'h0000;
            step_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
            step_q <= step_d;
        end
    end

    assign step_out = step_q;

endmodule : aws_step_timer

/* File: hdl/aws_ctrl.sv */
module aws_ctrl #(
    // Step timing; a bench may shorten it to reach sleep quickly
    parameter int TICK_CYCLES = aws_pkg::TICK_CYC,        // Clocks per tick
    parameter int SHORT_TICKS = aws_pkg::STEP_SHORT_TICK, // Ticks per step
    parameter int LONG_TICKS  = aws_pkg::STEP_LONG_TICK   // At 1.56 Hz
) (
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 sys_rst_in,
    // Host register access
    input  wire aws_pkg::aws_reg_req_t reg_req_in,
    output logic [7:0]                reg_rdata_out,
    // Detection events
    input  wire aws_pkg::aws_events_t events_in,
    input  wire logic                 fifo_flush_in,
    // System rate and status
    output aws_pkg::aws_rate_t        sys_rate_out,
    output logic                      asleep_out,
    output logic                      fifo_accept_out,
    output logic                      sleep_transition_event_out
);
    import aws_pkg::*;

    // Host registers
    logic [7:0]  inactivity_duration_q;
    logic [7:0]  inactivity_duration_d;
    logic [7:0]  system_control_one_q;
    logic [7:0]  system_control_one_d;
    logic [7:0]  system_control_two_q;
    logic [7:0]  system_control_two_d;
    logic [7:0]  wake_source_control_q;
    logic [7:0]  wake_source_control_d;
    logic [7:0]  interrupt_enable_control_q;
    logic [7:0]  interrupt_enable_control_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    // Sequencer state
    aws_state_t  state_q;
    aws_state_t  state_d;
    logic [7:0]  count_q;                  // Elapsed inactivity steps
    logic [7:0]  count_d;
    logic        aslp_en_q;                // Previous auto-sleep enable
    logic        sleep_evt_q;              // Sticky sleep transition flag
    logic        sleep_evt_d;
    logic        fifo_hold_q;              // FIFO refusing new samples
    logic        fifo_hold_d;
    aws_rate_t   rate_q;
    aws_rate_t   rate_d;
    logic        asleep_q;                 // Output copies from flops
    logic        asleep_d;
    logic        accept_q;
    logic        accept_d;

    // Decoded controls
    logic        active_en;
    logic        auto_sleep_enable;
    logic        fifo_gate_en;
    aws_rate_t   active_data_rate;
    logic [1:0]  sleep_sample_rate;
    logic        activity;
    logic        wake_req;
    logic        restart;
    logic        step;
    logic        long_step;
    logic        go_sleep;
    logic        go_wake;
    logic        ctl_wr;
    aws_rate_t   sleep_rate_code;

    // Field extraction
    always_comb begin
        active_en         = system_control_one_q[ACTIVE_BIT];
        active_data_rate  = aws_rate_t'(
            system_control_one_q[ACT_RATE_LSB +: 3]);
        sleep_sample_rate = system_control_one_q[SLEEP_RATE_LSB +: 2];
        auto_sleep_enable = system_control_two_q[AUTO_SLEEP_BIT];
        fifo_gate_en      = wake_source_control_q[FIFO_GATE_BIT];
    end

    // Sleep rate code to system rate
    always_comb begin
        case (sleep_sample_rate)
            2'b00:   sleep_rate_code = RATE_50;
            2'b01:   sleep_rate_code = RATE_12P5;
            2'b10:   sleep_rate_code = RATE_6P25;
            default: sleep_rate_code = RATE_1P56;
        endcase
    end

    // Activity and wake qualification
    always_comb begin
        // Only enabled functions count; sample-ready never does
        activity = (events_in.transient_event
                    & interrupt_enable_control_q[IEN_TRANS_BIT])
                 | (events_in.orientation_event
                    & interrupt_enable_control_q[IEN_ORIENT_BIT])
                 | (events_in.tap_event
                    & interrupt_enable_control_q[IEN_TAP_BIT])
                 | (events_in.freefall_motion_event
                    & interrupt_enable_control_q[IEN_FFMT_BIT]);
        // Wake needs both enable and wake selection
        wake_req = (events_in.transient_event
                    & interrupt_enable_control_q[IEN_TRANS_BIT]
                    & wake_source_control_q[WAKE_TRANS_BIT])
                 | (events_in.orientation_event
                    & interrupt_enable_control_q[IEN_ORIENT_BIT]
                    & wake_source_control_q[WAKE_ORIENT_BIT])
                 | (events_in.tap_event
                    & interrupt_enable_control_q[IEN_TAP_BIT]
                    & wake_source_control_q[WAKE_TAP_BIT])
                 | (events_in.freefall_motion_event
                    & interrupt_enable_control_q[IEN_FFMT_BIT]
                    & wake_source_control_q[WAKE_FFMT_BIT]);
    end

    // Transition decisions
    always_comb begin
        // Gate restarts but cannot wake
        restart  = activity | events_in.fifo_gate_event
                 | (auto_sleep_enable & ~aslp_en_q)
                 | (state_q != ST_WAKE);
        // Step is 640 ms only at the slowest active rate
        long_step = (active_data_rate == RATE_1P56);
        go_sleep = (state_q == ST_WAKE) & auto_sleep_enable
                 & ~restart & step
                 & (count_q + 8'h01 >= inactivity_duration_q);
        go_wake  = (state_q == ST_SLEEP) & wake_req;
    end

    // Inactivity step timer
    aws_step_timer #(
        .TICK_CYCLES  (TICK_CYCLES),
        .SHORT_TICKS  (SHORT_TICKS),
        .LONG_TICKS   (LONG_TICKS)
    ) u_step (
        .mclk_in      (mclk_in),
        .sys_rst_in   (sys_rst_in),
        .restart_in   (restart),
        .long_step_in (long_step),
        .step_out     (step)
    );

    // State, counter, rate and FIFO hold next values
    always_comb begin
        state_d     = state_q;
        count_d     = count_q;
        rate_d      = rate_q;
        sleep_evt_d = sleep_evt_q;
        fifo_hold_d = fifo_hold_q;
        case (state_q)
            ST_STANDBY: begin
                if (active_en) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (!active_en) begin
                    state_d = ST_STANDBY;
                end else if (go_sleep) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!active_en) begin
                    state_d = ST_STANDBY;
                end else if (go_wake || !auto_sleep_enable) begin
                    state_d = ST_WAKE;
                end
            end
            default: begin
                state_d = ST_STANDBY;
            end
        endcase
        // Step counting while awake
        if (restart) begin
            count_d = 8'h00;
        end else if (step && count_q != 8'hFF) begin
            count_d = count_q + 8'h01;
        end
        // Sleep rate overrides everything while asleep
        rate_d = (state_d == ST_SLEEP) ? sleep_rate_code : active_data_rate;
        // Sleep/wake interrupt; set wins over read clear
        if (rdata_clear()) begin
            sleep_evt_d = 1'b0;
        end
        if ((go_sleep || (state_q == ST_SLEEP && state_d == ST_WAKE))
            && interrupt_enable_control_q[IEN_SLEEP_BIT]) begin
            sleep_evt_d = 1'b1;
        end
        // FIFO hold when a gated transition newly sets the sleep flag, until flush
        if (fifo_flush_in) begin
            fifo_hold_d = 1'b0;
        end
        if (fifo_gate_en && sleep_evt_d && !sleep_evt_q) begin
            fifo_hold_d = 1'b1;
        end
        // Output copies track the next state and hold
        asleep_d = (state_d == ST_SLEEP);
        accept_d = ~fifo_hold_d;
    end

    // Reading the status register acknowledges the transition flag
    function automatic logic rdata_clear();
        rdata_clear = reg_req_in.rd && reg_req_in.addr == ADDR_SYS_STATUS;
    endfunction : rdata_clear

    // Host register writes and read data
    always_comb begin
        inactivity_duration_d      = inactivity_duration_q;
        system_control_one_d       = system_control_one_q;
        system_control_two_d       = system_control_two_q;
        wake_source_control_d      = wake_source_control_q;
        interrupt_enable_control_d = interrupt_enable_control_q;
        rdata_d                    = rdata_q;
        ctl_wr                     = reg_req_in.wr;
        if (ctl_wr) begin
            if (reg_req_in.addr == ADDR_INACT_DUR) begin
                inactivity_duration_d = reg_req_in.wdata;
            end else if (reg_req_in.addr == ADDR_SYS_CTRL1) begin
                system_control_one_d = reg_req_in.wdata;
            end else if (reg_req_in.addr == ADDR_SYS_CTRL2) begin
                system_control_two_d = reg_req_in.wdata;
            end else if (reg_req_in.addr == ADDR_WAKE_SRC) begin
                wake_source_control_d = reg_req_in.wdata;
            end else if (reg_req_in.addr == ADDR_INT_EN) begin
                interrupt_enable_control_d = reg_req_in.wdata;
            end
        end
        if (reg_req_in.rd) begin
            if (reg_req_in.addr == ADDR_INACT_DUR) begin
                rdata_d = inactivity_duration_q;
            end else if (reg_req_in.addr == ADDR_SYS_CTRL1) begin
                rdata_d = system_control_one_q;
            end else if (reg_req_in.addr == ADDR_SYS_CTRL2) begin
                rdata_d = system_control_two_q;
            end else if (reg_req_in.addr == ADDR_WAKE_SRC) begin
                rdata_d = wake_source_control_q;
            end else if (reg_req_in.addr == ADDR_INT_EN) begin
                rdata_d = interrupt_enable_control_q;
            end else if (reg_req_in.addr == ADDR_SYS_STATUS) begin
                rdata_d = {sleep_evt_q, fifo_hold_q, 4'h0, state_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // Registers
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            inactivity_duration_q      <= RST_INACT_DUR;
            system_control_one_q       <= RST_SYS_CTRL1;
            system_control_two_q       <= RST_SYS_CTRL2;
            wake_source_control_q      <= RST_WAKE_SRC;
            interrupt_enable_control_q <= RST_INT_EN;
            rdata_q                    <= 8'h00;
            state_q                    <= ST_STANDBY;
            count_q                    <= 8'h00;
            aslp_en_q                  <= 1'b0;
            sleep_evt_q                <= 1'b0;
            fifo_hold_q                <= 1'b0;
            asleep_q                   <= 1'b0;
            accept_q                   <= 1'b1;
            rate_q                     <= RATE_800;
        end else begin
            inactivity_duration_q      <= inactivity_duration_d;
            system_control_one_q       <= system_control_one_d;
            system_control_two_q       <= system_control_two_d;
            wake_source_control_q      <= wake_source_control_d;
            interrupt_enable_control_q <= interrupt_enable_control_d;
            rdata_q                    <= rdata_d;
            state_q                    <= state_d;
            count_q                    <= count_d;
            aslp_en_q                  <= auto_sleep_enable;
            sleep_evt_q                <= sleep_evt_d;
            fifo_hold_q                <= fifo_hold_d;
            asleep_q                   <= asleep_d;
            accept_q                   <= accept_d;
            rate_q                     <= rate_d;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_out              = rdata_q;
    assign sys_rate_out               = rate_q;
    assign asleep_out                 = asleep_q;
    assign fifo_accept_out            = accept_q;
    assign sleep_transition_event_out = sleep_evt_q;

endmodule : aws_ctrl

/* File: sim/aws_ctrl_assertions.sv */
module aws_ctrl_assertions import aws_pkg::*; (
    // Clock and reset
    input wire logic                  mclk_in,
    input wire logic                  sys_rst_in,
    // Host access
    input wire aws_pkg::aws_reg_req_t reg_req_in,
    input wire logic [7:0]            reg_rdata_out,
    // Events
    input wire aws_pkg::aws_events_t  events_in,
    input wire logic                  fifo_flush_in,
    // Rate and status
    input wire aws_pkg::aws_rate_t    sys_rate_out,
    input wire logic                  asleep_out,
    input wire logic                  fifo_accept_out,
    input wire logic                  sleep_transition_event_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Shadow copies of host writes
    logic [7:0] dur_q, dur_d;
    logic [7:0] ctl1_q, ctl1_d;
    logic       auto_sleep_enable_q, auto_sleep_enable_d;
    logic       unmapped;
    logic       wake_ev;

    assign unmapped = !(reg_req_in.addr inside {ADDR_INACT_DUR,
        ADDR_SYS_CTRL1, ADDR_SYS_CTRL2, ADDR_WAKE_SRC, ADDR_INT_EN,
        ADDR_SYS_STATUS});
    assign wake_ev = events_in.transient_event
        || events_in.orientation_event || events_in.tap_event
        || events_in.freefall_motion_event;

    // Next shadow values
    always_comb begin
        dur_d  = dur_q;
        ctl1_d = ctl1_q;
        auto_sleep_enable_d = auto_sleep_enable_q;
        if (reg_req_in.wr && reg_req_in.addr == ADDR_INACT_DUR) dur_d = reg_req_in.wdata;
        if (reg_req_in.wr && reg_req_in.addr == ADDR_SYS_CTRL1) ctl1_d = reg_req_in.wdata;
        if (reg_req_in.wr && reg_req_in.addr == ADDR_SYS_CTRL2)
            auto_sleep_enable_d = reg_req_in.wdata[AUTO_SLEEP_BIT];
    end

    // Shadow registers
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            dur_q  <= 8'h00;
            ctl1_q <= 8'h00;
            auto_sleep_enable_q <= 1'b0;
        end else begin
            dur_q  <= dur_d;
            ctl1_q <= ctl1_d;
            auto_sleep_enable_q <= auto_sleep_enable_d;
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Read of the duration byte
    sequence s_rd_dur;
        reg_req_in.rd && reg_req_in.addr == ADDR_INACT_DUR;
    endsequence
    // Asleep with only non-waking causes present
    sequence s_idle_sleep;
        asleep_out && auto_sleep_enable_q && !reg_req_in.wr && !wake_ev;
    endsequence

    a_dur_readback: assert property (s_rd_dur |=> reg_rdata_out == $past(dur_q))
        else $error("duration readback differs");
    a_unmapped_zero: assert property (reg_req_in.rd && unmapped |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_req_in.rd |=> $stable(reg_rdata_out))
        else $error("read data moved without read");
    a_reset_values: assert property ($fell(sys_rst_in) |-> sys_rate_out == RATE_800
        && !asleep_out && fifo_accept_out && !sleep_transition_event_out)
        else $error("outputs not at reset values");
    a_no_auto_sleep: assert property (!auto_sleep_enable_q [*3] |-> !asleep_out)
        else $error("asleep with auto-sleep off");
    a_wake_rate_sel: assert property ((!asleep_out && $stable(ctl1_q)) [*3]
        |-> sys_rate_out == ctl1_q[5:3])
        else $error("awake rate differs from active rate");
    a_sleep_rate_sel: assert property (asleep_out [*3]
        |-> sys_rate_out == {1'b1, ctl1_q[7:6]})
        else $error("sleep rate not applied");
    a_gate_no_wake: assert property (s_idle_sleep |=> asleep_out)
        else $error("woke without a wake source");
    a_event_cause: assert property ($rose(sleep_transition_event_out)
        |-> $past(asleep_out) != asleep_out)
        else $error("transition flag without transition");
    a_freeze_cause: assert property ($fell(fifo_accept_out)
        |-> sleep_transition_event_out)
        else $error("fifo held without sleep event");
    a_flush_resume: assert property (fifo_flush_in |=> fifo_accept_out
        || $rose(sleep_transition_event_out))
        else $error("fifo still held after flush");
endmodule : aws_ctrl_assertions

bind aws_ctrl aws_ctrl_assertions u_aws_chk (
    .mclk_in                    (mclk_in),
    .sys_rst_in                 (sys_rst_in),
    .reg_req_in                 (reg_req_in),
    .reg_rdata_out              (reg_rdata_out),
    .events_in                  (events_in),
    .fifo_flush_in              (fifo_flush_in),
    .sys_rate_out               (sys_rate_out),
    .asleep_out                 (asleep_out),
    .fifo_accept_out            (fifo_accept_out),
    .sleep_transition_event_out (sleep_transition_event_out)
);

/* File: sim/aws_host_model.sv */
module aws_host_model import aws_pkg::*; (
    // Clock
    input  wire logic           mclk_in,
    // Register access
    output aws_pkg::aws_reg_req_t reg_req_out,
    input  wire logic [7:0]     reg_rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial reg_req_out = '0;

    // One write, held for exactly one taking edge
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk_in);
        reg_req_out <= '0;
    endtask : reg_wr

    // One read, data picked up 1 ns after the taking edge, in the same cycle
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        reg_req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk_in);
        reg_req_out <= '0;
        #1;
        d = reg_rdata_in;
    endtask : reg_rd

    // Waking needs both the enable and the wake selection
    task automatic arm(input logic [7:0] ien, input logic [7:0] ws);
        reg_wr(ADDR_INT_EN, ien);
        reg_wr(ADDR_WAKE_SRC, ws);
    endtask : arm
endmodule : aws_host_model

/* File: sim/aws_ctrl_tb.sv */
module aws_ctrl_tb import aws_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 40000;       // Cycle ceiling for the run
    localparam logic [7:0] ADDRS [6] = '{ADDR_INACT_DUR, ADDR_SYS_CTRL1,
        ADDR_SYS_CTRL2, ADDR_WAKE_SRC, ADDR_INT_EN, ADDR_SYS_STATUS};

    logic         mclk_in    = 1'b0;
    logic         sys_rst_in = 1'b1;
    aws_reg_req_t reg_req;
    logic [7:0]   rdata;
    aws_events_t  events     = '0;
    logic         flush      = 1'b0;
    aws_rate_t    rate;
    logic         asleep, accept, sl_evt;
    logic         ev_on      = 1'b0;  // Random event traffic on
    int           errors     = 0;
    int           checks     = 0;
    int           cyc        = 0;
    logic [7:0]   d, r, a;

    always #4 mclk_in = ~mclk_in;

    // Short step timing so that sleep is reached in a short run
    aws_ctrl #(
        .TICK_CYCLES (4),
        .SHORT_TICKS (4),
        .LONG_TICKS  (8)
    ) uut (
        .mclk_in                    (mclk_in),
        .sys_rst_in                 (sys_rst_in),
        .reg_req_in                 (reg_req),
        .reg_rdata_out              (rdata),
        .events_in                  (events),
        .fifo_flush_in              (flush),
        .sys_rate_out               (rate),
        .asleep_out                 (asleep),
        .fifo_accept_out            (accept),
        .sleep_transition_event_out (sl_evt)
    );

    aws_host_model host (
        .mclk_in      (mclk_in),
        .reg_req_out  (reg_req),
        .reg_rdata_in (rdata)
    );

    // Compare and count
    task automatic chk(input logic [7:0] seen, exp, input string msg);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic results();
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // Status byte from flag, FIFO hold and power state
    function automatic logic [7:0] exp_stat(logic e, logic h, aws_state_t s);
        return {e, h, 4'h0, s};
    endfunction : exp_stat

    function automatic logic is_mapped(logic [7:0] x);
        foreach (ADDRS[i]) if (ADDRS[i] == x) return 1'b1;
        return 1'b0;
    endfunction : is_mapped

    // Random event pulses, flushes and the hang guard
    always @(posedge mclk_in) begin
        events <= (ev_on && $urandom_range(0, 7) == 0)
            ? aws_events_t'(6'($urandom)) : '0;
        flush  <= ev_on && ($urandom_range(0, 31) == 0);
        cyc    <= cyc + 1;
        if (cyc == LIMIT) begin
            errors++;
            results();
        end
    end

    initial begin
        void'($urandom(32'h1bc4_a436));
        repeat (5) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        chk({5'h00, rate}, {5'h00, RATE_800}, "reset rate");
        chk({5'h00, asleep, accept, sl_evt}, 8'h02, "reset flags");
        foreach (ADDRS[i]) begin
            host.reg_rd(ADDRS[i], r);
            chk(r, 8'h00, "reset register");
        end
        // Duration byte: both extremes, then random
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            host.reg_wr(ADDR_INACT_DUR, d);
            host.reg_rd(ADDR_INACT_DUR, r);
            chk(r, d, "duration readback");
        end
        // Unmapped places read zero and leave the duration byte alone
        for (int i = 0; i < 4; i++) begin
            do a = 8'($urandom); while (is_mapped(a));
            host.reg_wr(a, 8'($urandom));
            host.reg_rd(a, r);
            chk(r, 8'h00, "unmapped read");
            host.reg_rd(ADDR_INACT_DUR, r);
            chk(r, d, "unmapped write leak");
        end
        // Every active rate code, awake, back to standby between
        for (int i = 0; i < 8; i++) begin
            host.reg_wr(ADDR_SYS_CTRL1, {2'($urandom), 3'(i), 3'b001});
            repeat (3) @(posedge mclk_in);
            #1;
            chk({5'h00, rate}, 8'(i), "active rate");
            host.reg_rd(ADDR_SYS_STATUS, r);
            chk(r, exp_stat(1'b0, 1'b0, ST_WAKE), "wake state");
            host.reg_wr(ADDR_SYS_CTRL1, 8'h00);
        end
        // Auto-sleep with traffic, then quiet: eight steps to sleep
        a = {2'($urandom), 6'h01};
        host.arm(8'hbc, 8'hf8);
        host.reg_wr(ADDR_INACT_DUR, 8'h08);
        host.reg_wr(ADDR_SYS_CTRL1, a);
        host.reg_wr(ADDR_SYS_CTRL2, 8'h04);
        ev_on <= 1'b1;
        repeat (300) @(posedge mclk_in);
        ev_on <= 1'b0;
        repeat (100) @(posedge mclk_in);
        #1;
        chk({7'h00, asleep}, 8'h00, "early sleep");
        repeat (100) @(posedge mclk_in);
        #1;
        chk({7'h00, asleep}, 8'h01, "no sleep");
        chk({5'h00, rate}, {5'h00, 1'b1, a[7:6]}, "sleep rate");
        chk({7'h00, accept}, 8'h00, "fifo held");
        host.reg_rd(ADDR_SYS_STATUS, r);
        chk(r, exp_stat(1'b1, 1'b1, ST_SLEEP), "sleep status");
        // Wake sources in the traffic wake it; flushes free the FIFO
        ev_on <= 1'b1;
        repeat (400) @(posedge mclk_in);
        ev_on <= 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
        chk({7'h00, asleep}, 8'h00, "no wake");
        chk({7'h00, accept}, 8'h01, "fifo after flush");
        host.reg_rd(ADDR_SYS_STATUS, r);
        chk(r, exp_stat(1'b1, 1'b0, ST_WAKE), "wake status");
        // Quiet again until asleep, then a second reset
        repeat (200) @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        host.reg_rd(ADDR_INACT_DUR, r);
        chk(r, 8'h00, "second reset");
        chk({5'h00, rate}, {5'h00, RATE_800}, "rate after reset");
        chk({5'h00, asleep, accept, sl_evt}, 8'h02, "flags");
        results();
    end
endmodule : aws_ctrl_tb
